// file: pkg/tblcc_pkg.sv
package tblcc_pkg;
	// register offsets on the plain register port (index = printed register)
	localparam logic [4:0] REG_STATUS = 5'h01;
	localparam logic [4:0] REG_DETAIL = 5'h11;
	localparam logic [4:0] REG_CTRL = 5'h12;
	localparam logic [4:0] REG_MODE = 5'h13;
	// field positions
	localparam int STATUS_LINK_BIT = 2;
	localparam int DETAIL_LINK_BIT = 0;
	localparam int DETAIL_JAB_BIT = 2;
	localparam int CTRL_SQUELCH_INH_BIT = 0;
	localparam int CTRL_SQE_INH_BIT = 2;
	localparam int CTRL_JAB_INH_BIT = 5;
	localparam int MODE_FDX_BIT = 0;
	localparam int MODE_RPT_BIT = 1;
	// reset values
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] MODE_RESET = 16'h0000;
	// timing, 40 MHz core clock
	localparam longint CLK_HZ = 40000000;
	localparam longint PULSE_PERIOD_MS = 16;
	localparam longint PULSE_PERIOD_CYC = PULSE_PERIOD_MS * CLK_HZ / 1000;
	localparam longint LINK_LOSS_MS = 82;
	localparam longint LINK_LOSS_CYC = LINK_LOSS_MS * CLK_HZ / 1000;
	localparam longint JAB_MAX_MS = 20;
	localparam longint JAB_MAX_CYC = JAB_MAX_MS * CLK_HZ / 1000;
	localparam longint JAB_OFF_MS = 500;
	localparam longint JAB_OFF_CYC = JAB_OFF_MS * CLK_HZ / 1000;
	localparam longint SQE_NS = 1000;
	localparam longint SQE_CYC = (SQE_NS * CLK_HZ + 999999999) / 1000000000;
	localparam longint BIT_NS = 100;
	localparam longint BIT_CYC = (BIT_NS * CLK_HZ + 999999999) / 1000000000;
	localparam int LOCK_BITS = 3;
	localparam int LINK_PULSES = 7;
	// register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [15:0] wdata;
	} tblcc_req_t;
	// mac side signals
	typedef struct packed {
		logic crs;
		logic col;
	} tblcc_mac_t;
	// link monitor states
	typedef enum logic [1:0] {
		LM_DOWN = 2'b00,
		LM_WAIT_END = 2'b01,
		LM_UP = 2'b10
	} tblcc_lm_t;
endpackage

// file: src/tblcc_core.sv
`timescale 1ns/10ps
module tblcc_core #(
	parameter longint PULSE_CYC = tblcc_pkg::PULSE_PERIOD_CYC,
	parameter longint LOSS_CYC = tblcc_pkg::LINK_LOSS_CYC,
	parameter longint JMAX_CYC = tblcc_pkg::JAB_MAX_CYC,
	parameter longint JOFF_CYC = tblcc_pkg::JAB_OFF_CYC
) (
	input wire logic core_clk, // 40 MHz clock
	input wire logic reset_n, // async reset, active low
	input wire tblcc_pkg::tblcc_req_t req, // register request
	output logic [15:0] rdata, // read data, cycle after strobe
	input wire logic tx_en, // mac transmit enable
	input wire logic rx_active, // receiver sees carrier
	input wire logic rx_preamble, // preamble seen on line
	input wire logic rx_clk_ok, // clock extracted this cycle
	input wire logic rx_pulse, // valid link pulse received, pulse
	input wire logic rx_marker, // valid idle marker received, pulse
	output tblcc_pkg::tblcc_mac_t mac, // carrier sense and collision
	output logic pll_acquire, // recovery loop acquiring
	output logic tx_pass, // transmit data reaches line
	output logic tx_pulse, // send link pulse, one cycle
	output logic tx_marker, // send idle marker, one cycle
	output logic link_up // current link state
);
	localparam int CW = 26;
	logic [15:0] ctrl_r;
	logic [15:0] mode_r;
	logic squelch_on, sqe_on, jab_on, fdx, rpt;
	logic link_flag_r, jab_flag_r, rd_status, rd_detail;
	logic [CW-1:0] pulse_cnt_r, loss_cnt_r, jab_cnt_r;
	logic [3:0] npulse_r;
	logic [7:0] lock_cnt_r;
	logic valid_data_r, marker_seen_r, rx_d_r, tx_d_r, jabbing_r;
	logic [5:0] sqe_cnt_r;
	tblcc_pkg::tblcc_lm_t lm_r, lm_nxt;

	function automatic logic hit(input tblcc_pkg::tblcc_req_t q,
		input logic [4:0] a);
		hit = q.addr == a;
	endfunction

	assign squelch_on = ~ctrl_r[tblcc_pkg::CTRL_SQUELCH_INH_BIT];
	assign jab_on = ~ctrl_r[tblcc_pkg::CTRL_JAB_INH_BIT];
	assign sqe_on = ~ctrl_r[tblcc_pkg::CTRL_SQE_INH_BIT];
	assign fdx = mode_r[tblcc_pkg::MODE_FDX_BIT];
	assign rpt = mode_r[tblcc_pkg::MODE_RPT_BIT];
	assign rd_status = req.rd & hit(req, tblcc_pkg::REG_STATUS);
	assign rd_detail = req.rd & hit(req, tblcc_pkg::REG_DETAIL);
	assign link_up = lm_r == tblcc_pkg::LM_UP;

	// writable control and mode registers
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_r <= tblcc_pkg::CTRL_RESET;
			mode_r <= tblcc_pkg::MODE_RESET;
		end else if (req.wr) begin
			if (hit(req, tblcc_pkg::REG_CTRL))
				ctrl_r <= req.wdata;
			if (hit(req, tblcc_pkg::REG_MODE))
				mode_r <= req.wdata;
		end
	end

	// read data, one cycle after strobe, zero when unmapped
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata <= 16'h0000;
		end else if (req.rd) begin
			rdata <= 16'h0000;
			case (req.addr)
				tblcc_pkg::REG_STATUS:
					rdata[tblcc_pkg::STATUS_LINK_BIT] <= link_flag_r;
				tblcc_pkg::REG_DETAIL: begin
					rdata[tblcc_pkg::DETAIL_LINK_BIT] <= link_flag_r;
					rdata[tblcc_pkg::DETAIL_JAB_BIT] <= jab_flag_r;
				end
				tblcc_pkg::REG_CTRL: rdata <= ctrl_r;
				tblcc_pkg::REG_MODE: rdata <= mode_r;
				default: rdata <= 16'h0000;
			endcase
		end else begin
			rdata <= 16'h0000;
		end
	end

	// latched-low link flag: drop wins, read reloads current state
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			link_flag_r <= 1'b0;
		else if (!link_up)
			link_flag_r <= 1'b0;
		else if (rd_status | rd_detail)
			link_flag_r <= 1'b1;
	end

	// latched-high jabber flag: set wins over read
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			jab_flag_r <= 1'b0;
		else if (jabbing_r)
			jab_flag_r <= 1'b1;
		else if (rd_detail)
			jab_flag_r <= 1'b0;
	end

	// link pulse timer, runs regardless of receive activity
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			pulse_cnt_r <= '0;
		else if ((tx_en & ~jabbing_r) || pulse_cnt_r == CW'(PULSE_CYC - 1))
			pulse_cnt_r <= '0;
		else
			pulse_cnt_r <= pulse_cnt_r + 1'b1;
	end
	// pulses sent when idle or jabbing, even when receiving
	assign tx_pulse = (~tx_en | jabbing_r) &&
		pulse_cnt_r == CW'(PULSE_CYC - 1);

	// idle marker after every transmitted packet
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			tx_d_r <= 1'b0;
		else
			tx_d_r <= tx_en;
	end
	assign tx_marker = tx_d_r & ~tx_en;

	// recovery loop acquires from preamble for the whole reception
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			pll_acquire <= 1'b0;
		else if (!rx_active)
			pll_acquire <= 1'b0;
		else if (rx_preamble)
			pll_acquire <= 1'b1;
	end

	// valid data after three consecutive locked bit times
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			lock_cnt_r <= '0;
			valid_data_r <= 1'b0;
		end else if (!rx_active) begin
			lock_cnt_r <= '0;
			valid_data_r <= 1'b0;
		end else if (!(pll_acquire & rx_clk_ok)) begin
			lock_cnt_r <= '0;
		end else if (lock_cnt_r == 8'(tblcc_pkg::LOCK_BITS *
			tblcc_pkg::BIT_CYC - 1)) begin
			valid_data_r <= 1'b1;
		end else begin
			lock_cnt_r <= lock_cnt_r + 1'b1;
		end
	end

	// idle marker seen after valid data in this packet
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			marker_seen_r <= 1'b0;
		else if (rx_active & ~rx_d_r)
			marker_seen_r <= 1'b0;
		else if (rx_marker & valid_data_r)
			marker_seen_r <= 1'b1;
	end

	// receive start detect
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			rx_d_r <= 1'b0;
		else
			rx_d_r <= rx_active;
	end

	// count received link pulses while down
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			npulse_r <= '0;
		else if (lm_r != tblcc_pkg::LM_DOWN)
			npulse_r <= '0;
		else if (rx_pulse && npulse_r != 4'(tblcc_pkg::LINK_PULSES + 1))
			npulse_r <= npulse_r + 1'b1;
	end

	// link monitor next state
	always_comb begin
		lm_nxt = lm_r;
		case (lm_r)
			tblcc_pkg::LM_DOWN:
				if (npulse_r > 4'(tblcc_pkg::LINK_PULSES))
					lm_nxt = tblcc_pkg::LM_UP;
				else if (valid_data_r)
					lm_nxt = tblcc_pkg::LM_WAIT_END;
			tblcc_pkg::LM_WAIT_END:
				if (!rx_active)
					lm_nxt = (!squelch_on || marker_seen_r) ?
						tblcc_pkg::LM_UP : tblcc_pkg::LM_DOWN;
			tblcc_pkg::LM_UP:
				if (loss_cnt_r == CW'(LOSS_CYC - 1))
					lm_nxt = tblcc_pkg::LM_DOWN;
			default: lm_nxt = tblcc_pkg::LM_DOWN;
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			lm_r <= tblcc_pkg::LM_DOWN;
		else
			lm_r <= lm_nxt;
	end

	// activity timeout, restarted by pulses or qualifying data
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			loss_cnt_r <= '0;
		else if (!link_up || rx_pulse || (valid_data_r &&
			(!squelch_on || rx_marker)))
			loss_cnt_r <= '0;
		else
			loss_cnt_r <= loss_cnt_r + 1'b1;
	end

	// jabber: overlong transmit, then blocked for deactivation time
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			jab_cnt_r <= '0;
			jabbing_r <= 1'b0;
		end else if (jabbing_r) begin
			if (jab_cnt_r == CW'(JOFF_CYC - 1)) begin
				jabbing_r <= 1'b0;
				jab_cnt_r <= '0;
			end else begin
				jab_cnt_r <= jab_cnt_r + 1'b1;
			end
		end else if (!(tx_en & jab_on)) begin
			jab_cnt_r <= '0;
		end else if (jab_cnt_r == CW'(JMAX_CYC - 1)) begin
			jabbing_r <= 1'b1;
			jab_cnt_r <= '0;
		end else begin
			jab_cnt_r <= jab_cnt_r + 1'b1;
		end
	end
	assign tx_pass = tx_en & ~jabbing_r;

	// heartbeat collision after transmit end
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			sqe_cnt_r <= '0;
		else if (tx_marker && sqe_on && !fdx && !rpt && link_up)
			sqe_cnt_r <= 6'(tblcc_pkg::SQE_CYC);
		else if (sqe_cnt_r != 6'h00)
			sqe_cnt_r <= sqe_cnt_r - 1'b1;
	end

	// carrier sense and collision to mac
	always_comb begin
		mac.crs = (fdx | rpt) ? rx_active : (rx_active | tx_en);
		mac.col = 1'b0;
		if (!fdx)
			mac.col = (rx_active & tx_en) | jabbing_r |
				(sqe_cnt_r != 6'h00);
	end

	// checks on mac signalling, link monitor, jabber and heartbeat
	AST_CRS_HDX: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		!fdx && !rpt && tx_en |-> mac.crs)
		else $error("carrier missing during half duplex transmit");
	AST_CRS_FDX: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		(fdx || rpt) && !rx_active |-> !mac.crs)
		else $error("carrier from own transmit in full duplex");
	AST_COL_HDX: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		!fdx && tx_en && rx_active |-> mac.col)
		else $error("collision missing");
	AST_COL_FDX: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		fdx |-> !mac.col)
		else $error("collision in full duplex");
	AST_PULSE_COL: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		tx_pulse && !tx_en && !jabbing_r && sqe_cnt_r == 6'h00
		|-> !mac.col)
		else $error("collision from link pulse");
	AST_MARKER: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		$fell(tx_en) |-> tx_marker)
		else $error("idle marker not sent");
	AST_PLL: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		rx_active && rx_preamble |=> pll_acquire)
		else $error("recovery loop not acquiring");
	AST_JAB: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		$rose(jabbing_r) |-> ##1
		(jab_flag_r && !tx_pass && mac.col == !fdx))
		else $error("jabber response wrong");
	AST_NOJAB: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		!jab_on && !jabbing_r |=> !jabbing_r)
		else $error("jabber while detection inhibited");
	AST_LINK_LL: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		$fell(link_up) |=> !link_flag_r)
		else $error("link flag not latched low");
	AST_UP_NOFLAG: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		!link_flag_r && !rd_status && !rd_detail |=> !link_flag_r)
		else $error("link flag set without read");
	AST_JAB_HOLD: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		jab_flag_r && !rd_detail |=> jab_flag_r)
		else $error("jabber flag lost before read");
	AST_SQE: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		$fell(tx_en) && sqe_on && !fdx && !rpt && link_up && !rx_active
		|=> mac.col [*6])
		else $error("heartbeat too short");
	AST_SQE_OFF: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		tx_marker && (!sqe_on || fdx || rpt || !link_up) &&
		sqe_cnt_r == 6'h00 |=> sqe_cnt_r == 6'h00)
		else $error("heartbeat while suppressed");
	AST_WAIT: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		lm_r == tblcc_pkg::LM_WAIT_END && rx_active |=> !link_up)
		else $error("link up before packet end");
	COV_UP: cover property (@(posedge core_clk) $rose(link_up));
	COV_DOWN: cover property (@(posedge core_clk) $fell(link_up));
	COV_JAB: cover property (@(posedge core_clk) $rose(jabbing_r));
	COV_SQE: cover property (@(posedge core_clk) $rose(sqe_cnt_r != 6'h00));
endmodule // tblcc_core

// file: dv/tblcc_far.sv
`timescale 1ns/10ps
module tblcc_far (
	input wire logic core_clk, // core clock
	output logic rx_active, // carrier on line
	output logic rx_preamble, // preamble seen
	output logic rx_clk_ok, // clock extracted
	output logic rx_pulse, // link pulse seen
	output logic rx_marker // idle marker seen
);
	// line silent at start
	initial begin
		{rx_active, rx_preamble, rx_clk_ok, rx_pulse, rx_marker} = '0;
	end
	// n link pulses, gap+1 idle cycles apart
	task automatic pulses(input int n, input int gap);
		repeat (n) begin
			@(posedge core_clk) rx_pulse <= 1'b1;
			@(posedge core_clk) rx_pulse <= 1'b0;
			repeat (gap) @(posedge core_clk);
		end
	endtask
	// one frame, clock locked len+2 cycles, marker at its tail
	task automatic frame(input int len, input logic mark);
		@(posedge core_clk) {rx_active, rx_preamble} <= 2'b11;
		@(posedge core_clk) {rx_preamble, rx_clk_ok} <= 2'b01;
		repeat (len) @(posedge core_clk);
		@(posedge core_clk) rx_marker <= mark;
		@(posedge core_clk) {rx_active, rx_clk_ok, rx_marker} <= 3'b000;
	endtask
endmodule // tblcc_far

// file: dv/tb.sv
`timescale 1ns/10ps
module tb;
	logic core_clk, reset_n, tx_en;
	logic rx_active, rx_preamble, rx_clk_ok, rx_pulse, rx_marker;
	logic pll_acquire, tx_pass, tx_pulse, tx_marker, link_up;
	logic [15:0] rdata;
	tblcc_pkg::tblcc_req_t req;
	tblcc_pkg::tblcc_mac_t mac;
	int bad_count = 0;
	int n_tests = 0;
	// scaled timers keep the run short
	tblcc_core #(.PULSE_CYC(64), .LOSS_CYC(400), .JMAX_CYC(100),
		.JOFF_CYC(200)) dut (.core_clk(core_clk), .reset_n(reset_n),
		.req(req), .rdata(rdata), .tx_en(tx_en), .rx_active(rx_active),
		.rx_preamble(rx_preamble), .rx_clk_ok(rx_clk_ok),
		.rx_pulse(rx_pulse), .rx_marker(rx_marker), .mac(mac),
		.pll_acquire(pll_acquire), .tx_pass(tx_pass),
		.tx_pulse(tx_pulse), .tx_marker(tx_marker), .link_up(link_up));
	tblcc_far far (.core_clk(core_clk), .rx_active(rx_active),
		.rx_preamble(rx_preamble), .rx_clk_ok(rx_clk_ok),
		.rx_pulse(rx_pulse), .rx_marker(rx_marker));
	// clock
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// hang guard
	initial begin
		#1ms;
		bad_count++;
		print_verdict();
	end
	task automatic print_verdict();
		if (bad_count == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// compare and report
	task automatic chk(input logic [15:0] got, exp, input string m);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge core_clk) req <= '{1'b1, 1'b0, a, d};
		@(posedge core_clk) req <= '0;
	endtask
	// read, data checked in the cycle after the strobe
	task automatic rv(input logic [4:0] a, input logic [15:0] k, e,
		input string m);
		@(posedge core_clk) req <= '{1'b0, 1'b1, a, 16'h0000};
		@(posedge core_clk) req <= '0;
		#1;
		chk(rdata & k, e, m);
	endtask
	task automatic t_reset();
		rv(5'h12, 16'hffff, 16'h0000, "ctrl");
		rv(5'h13, 16'hffff, 16'h0000, "mode");
		wr(5'h12, 16'h0025);
		rv(5'h12, 16'hffff, 16'h0025, "ctrl rw");
		wr(5'h05, 16'hffff);
		rv(5'h05, 16'hffff, 16'h0000, "unmapped");
		wr(5'h12, 16'h0000);
	endtask
	task automatic t_link();
		far.pulses(7, 3);
		cyc(3);
		chk(link_up, 0, "seven pulses");
		far.pulses(1, 3);
		cyc(3);
		chk(link_up, 1, "eight pulses");
		rv(5'h01, 16'h0004, 16'h0000, "latched");
		rv(5'h11, 16'h0001, 16'h0001, "after read");
	endtask
	// pulses keep coming while a frame arrives
	task automatic t_idle();
		logic [15:0] np = '0;
		logic [15:0] nc = '0;
		fork
			far.frame(120, 1'b1);
			repeat (128) begin
				cyc(1);
				np += tx_pulse;
				nc += mac.col;
			end
		join
		chk(np, 2, "pulse rate");
		chk(nc, 0, "idle col");
	endtask
	// heartbeat after transmit end, gated by mode and inhibit
	task automatic t_sqe(input logic [15:0] c, m, input int ncol);
		logic [15:0] nc = '0;
		logic [15:0] nm = '0;
		wr(5'h12, c);
		wr(5'h13, m);
		far.pulses(1, 0);
		@(posedge core_clk) tx_en <= 1'b1;
		cyc(4);
		chk(mac.crs, m == 0, "crs on tx");
		@(posedge core_clk) tx_en <= 1'b0;
		repeat (60) begin
			#1;
			nc += mac.col;
			nm += tx_marker;
			@(posedge core_clk);
		end
		chk(nc, ncol, "heartbeat");
		chk(nm, 1, "idle marker");
	endtask
	// own transmit overlapping reception
	task automatic t_coll(input logic [15:0] m);
		wr(5'h13, m);
		fork
			far.frame(30, 1'b1);
			begin
				cyc(8);
				chk(pll_acquire, 1, "acquire");
				chk(mac, 2'b10, "crs rx");
				@(posedge core_clk) tx_en <= 1'b1;
				cyc(2);
				chk(mac.col, m == 0, "collision");
				@(posedge core_clk) tx_en <= 1'b0;
			end
		join
		cyc(50);
	endtask
	task automatic t_jab(input logic [15:0] c);
		logic [15:0] np = '0;
		wr(5'h12, c);
		@(posedge core_clk) tx_en <= 1'b1;
		cyc(110);
		chk(tx_pass, c != 0, "tx cut");
		chk(mac.col, c == 0, "jab col");
		repeat (64) begin
			cyc(1);
			np += tx_pulse;
		end
		chk(np, c == 0, "jab pulses");
		@(posedge core_clk) tx_en <= 1'b0;
		cyc(250);
		rv(5'h11, 16'h0004, {13'h0, c == 0, 2'b00}, "jab");
	endtask
	task automatic t_loss();
		far.pulses(8, 2);
		cyc(300);
		chk(link_up, 1, "holds");
		cyc(120);
		chk(link_up, 0, "timeout");
		rv(5'h01, 16'h0004, 16'h0000, "dropped");
	endtask
	task automatic t_data();
		far.frame(1, 1'b1);
		cyc(3);
		chk(link_up, 0, "short burst");
		far.frame(20, 1'b0);
		cyc(3);
		chk(link_up, 0, "no marker");
		fork
			far.frame(20, 1'b1);
			begin
				cyc(18);
				chk(link_up, 0, "deferred");
			end
		join
		cyc(3);
		chk(link_up, 1, "data marker");
		cyc(420);
		wr(5'h12, 16'h0001);
		far.frame(20, 1'b0);
		cyc(3);
		chk(link_up, 1, "data only");
	endtask
	// main sequence
	initial begin
		reset_n = 1'b0;
		tx_en = 1'b0;
		req = '0;
		repeat (20) @(posedge core_clk);
		reset_n <= 1'b1;
		t_reset();
		t_link();
		t_idle();
		t_sqe(16'h0000, 16'h0000, int'(tblcc_pkg::SQE_CYC));
		t_sqe(16'h0004, 16'h0000, 0);
		t_sqe(16'h0000, 16'h0001, 0);
		t_sqe(16'h0000, 16'h0002, 0);
		t_coll(16'h0001);
		t_coll(16'h0000);
		t_jab(16'h0000);
		t_jab(16'h0020);
		t_loss();
		t_data();
		print_verdict();
	end
endmodule // tb
